// ===== design/qdscd_pkg.sv
package qdscd_pkg;

  // ----------------------------------------------------------------
  // Command word layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_BITS   = 24;
  localparam int unsigned RW_POS      = 23;
  localparam int unsigned RSVD_POS    = 22;
  localparam int unsigned TGT_MSB     = 21;
  localparam int unsigned TGT_LSB     = 19;
  localparam int unsigned CHAN_MSB    = 18;
  localparam int unsigned CHAN_LSB    = 16;
  localparam int unsigned DATA_MSB    = 15;
  localparam int unsigned DATA_LSB    = 0;
  localparam int unsigned CODE_MSB    = 15;
  localparam int unsigned CODE_LSB    = 4;
  localparam int unsigned CODE_BITS   = 12;
  localparam int unsigned LEVEL_BITS  = 13;
  localparam int unsigned NUM_CHAN    = 4;
  localparam int unsigned RANGE_BITS  = 3;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic        RW_WRITE    = 1'b0;
  localparam logic [2:0]  TGT_CONV    = 3'h0;
  localparam logic [2:0]  TGT_RANGE   = 3'h1;
  localparam logic [2:0]  TGT_POWER   = 3'h2;
  localparam logic [2:0]  TGT_CTRL    = 3'h3;
  localparam logic [2:0]  CHAN_ALL    = 3'h4;
  localparam logic [2:0]  RANGE_BIPOLAR_MIN = 3'h3;

  // Offset binary midscale code gives zero output
  localparam logic [12:0] OFFSET_MID  = 13'h0800;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CONV_RST    = 16'h0000;
  localparam logic [15:0] RANGE_RST   = 16'h0000;
  localparam logic [15:0] POWER_RST   = 16'h0000;
  localparam logic [15:0] CTRL_RST    = 16'h0000;
  localparam logic [23:0] WORD_RST    = 24'h00_0000;
  localparam logic [4:0]  BITS_RST    = 5'h00;
  localparam logic [4:0]  LAST_BIT    = 5'h17;

  // Command handler states, Gray coded along the path
  typedef enum logic [1:0] {
    QDSCD_IDLE   = 2'b00,
    QDSCD_DECODE = 2'b01,
    QDSCD_ANSWER = 2'b11
  } qdscd_state_e;

endpackage : qdscd_pkg

// ===== design/qdscd_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser; the first stage feeds only the second
module qdscd_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // ----------------------------------------------------------------
  // Two flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule : qdscd_sync

`default_nettype wire

// ===== design/qdscd_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module qdscd_decoder (
  // System clock and reset
  input  wire logic                                      mclk_i,
  input  wire logic                                      sys_rst_i,
  // Serial link from the host
  input  wire logic                                      serial_clock_i,
  input  wire logic                                      frame_sync_n_i,
  input  wire logic                                      serial_data_input_i,
  // Coding selection pin for bipolar ranges
  input  wire logic                                      twos_comp_pin_i,
  // Per-channel conversion results
  output logic      [qdscd_pkg::NUM_CHAN-1:0][qdscd_pkg::CODE_BITS-1:0]  chan_code_o,
  output logic      [qdscd_pkg::NUM_CHAN-1:0][qdscd_pkg::LEVEL_BITS-1:0] chan_level_o,
  output logic      [qdscd_pkg::NUM_CHAN-1:0]                            chan_bipolar_o,
  output logic      [qdscd_pkg::NUM_CHAN-1:0][qdscd_pkg::RANGE_BITS-1:0] chan_range_o,
  // Register contents
  output logic      [15:0]                               power_ctrl_o,
  output logic      [15:0]                               gen_ctrl_o,
  // Command status
  output logic      [15:0]                               readback_data_o,
  output logic                                           readback_valid_o,
  output logic                                           write_done_o,
  output logic                                           cmd_ignored_o
);
  import qdscd_pkg::*;

  // ----------------------------------------------------------------
  // Link domain: shift register and bit counter
  // ----------------------------------------------------------------
  logic [23:0] shift_reg;
  logic [4:0]  bits_reg;
  logic [23:0] word_reg;
  logic        word_tgl_reg;

  // Shift in MSB first while the frame is active
  always_ff @(posedge serial_clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_reg <= WORD_RST;
    end else if (!frame_sync_n_i) begin
      shift_reg <= {shift_reg[22:0], serial_data_input_i};
    end
  end

  // Count positions; raising the frame clears the count at once, because the
  // link clock stands still between frames and a cut word must not linger
  always_ff @(posedge serial_clock_i or posedge sys_rst_i or posedge frame_sync_n_i) begin
    if (sys_rst_i) begin
      bits_reg <= BITS_RST;
    end else if (frame_sync_n_i) begin
      bits_reg <= BITS_RST;
    end else if (bits_reg == LAST_BIT) begin
      bits_reg <= BITS_RST;
    end else begin
      bits_reg <= bits_reg + 5'h01;
    end
  end

  // Capture the full word and toggle to signal the other domain
  always_ff @(posedge serial_clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      word_reg     <= WORD_RST;
      word_tgl_reg <= 1'b0;
    end else if (!frame_sync_n_i && bits_reg == LAST_BIT) begin
      word_reg     <= {shift_reg[22:0], serial_data_input_i};
      word_tgl_reg <= ~word_tgl_reg;
    end
  end

  // ----------------------------------------------------------------
  // Crossing into the system clock
  // ----------------------------------------------------------------
  logic [1:0] sync_out;
  logic       tgl_seen_reg;
  logic       coding_tc;
  logic       word_arrived;

  qdscd_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_i   (mclk_i),
    .rst_i   (sys_rst_i),
    .async_i ({twos_comp_pin_i, word_tgl_reg}),
    .sync_o  (sync_out)
  );

  assign coding_tc    = sync_out[1];
  assign word_arrived = sync_out[0] ^ tgl_seen_reg;

  // Remember the last toggle level handled
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tgl_seen_reg <= 1'b0;
    end else begin
      tgl_seen_reg <= sync_out[0];
    end
  end

  // ----------------------------------------------------------------
  // Command capture and field split
  // ----------------------------------------------------------------
  logic [23:0]  cmd_reg;
  qdscd_state_e state_reg;
  qdscd_state_e state_next;

  // Word is stable for 24 link clocks, long after the toggle settles
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_reg <= WORD_RST;
    end else if (state_reg == QDSCD_IDLE && word_arrived) begin
      cmd_reg <= word_reg;
    end
  end

  logic        cmd_read;
  logic [2:0]  cmd_tgt;
  logic [2:0]  cmd_chan;
  logic [15:0] cmd_data;
  logic        tgt_ok;
  logic        chan_ok;

  assign cmd_read = (cmd_reg[RW_POS] != RW_WRITE);
  assign cmd_tgt  = cmd_reg[TGT_MSB:TGT_LSB];
  assign cmd_chan = cmd_reg[CHAN_MSB:CHAN_LSB];
  assign cmd_data = cmd_reg[DATA_MSB:DATA_LSB];
  assign tgt_ok   = (cmd_tgt == TGT_CONV) || (cmd_tgt == TGT_RANGE)
                 || (cmd_tgt == TGT_POWER) || (cmd_tgt == TGT_CTRL);
  assign chan_ok  = (cmd_chan <= CHAN_ALL);

  // Channel enable mask from the channel select
  logic [NUM_CHAN-1:0] chan_mask;
  always_comb begin
    chan_mask = '0;
    if (cmd_chan == CHAN_ALL) begin
      chan_mask = '1;
    end else if (cmd_chan < CHAN_ALL) begin
      chan_mask[cmd_chan[1:0]] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Command state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      QDSCD_IDLE: begin
        if (word_arrived) begin
          state_next = QDSCD_DECODE;
        end
      end
      QDSCD_DECODE: begin
        state_next = QDSCD_ANSWER;
      end
      QDSCD_ANSWER: begin
        state_next = QDSCD_IDLE;
      end
      default: begin
        state_next = QDSCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= QDSCD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  logic do_cmd;
  logic do_write;
  assign do_cmd   = (state_reg == QDSCD_DECODE) && tgt_ok;
  assign do_write = do_cmd && !cmd_read && chan_ok;

  // ----------------------------------------------------------------
  // Target registers
  // ----------------------------------------------------------------
  logic [NUM_CHAN-1:0][15:0] conv_reg;
  logic [NUM_CHAN-1:0][15:0] range_reg;
  logic [15:0]               power_reg;
  logic [15:0]               ctrl_reg;

  // Per-channel conversion and range stores
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        conv_reg[i]  <= CONV_RST;
        range_reg[i] <= RANGE_RST;
      end
    end else if (do_write) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (chan_mask[i] && cmd_tgt == TGT_CONV) begin
          conv_reg[i] <= cmd_data;
        end
        if (chan_mask[i] && cmd_tgt == TGT_RANGE) begin
          range_reg[i] <= cmd_data;
        end
      end
    end
  end

  // Device-wide power and control stores
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      power_reg <= POWER_RST;
      ctrl_reg  <= CTRL_RST;
    end else if (do_write) begin
      if (cmd_tgt == TGT_POWER) begin
        power_reg <= cmd_data;
      end
      if (cmd_tgt == TGT_CTRL) begin
        ctrl_reg <= cmd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read-back and status
  // ----------------------------------------------------------------
  logic [1:0]  rd_chan;
  logic [15:0] rd_value;

  assign rd_chan = (cmd_chan == CHAN_ALL) ? 2'h0 : cmd_chan[1:0];

  // Pick the addressed register contents
  always_comb begin
    rd_value = 16'h0000;
    unique case (cmd_tgt)
      TGT_CONV:  rd_value = conv_reg[rd_chan];
      TGT_RANGE: rd_value = range_reg[rd_chan];
      TGT_POWER: rd_value = power_reg;
      TGT_CTRL:  rd_value = ctrl_reg;
      default:   rd_value = 16'h0000;
    endcase
  end

  // One-cycle status pulses, read data held until the next read
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      readback_data_o  <= 16'h0000;
      readback_valid_o <= 1'b0;
      write_done_o     <= 1'b0;
      cmd_ignored_o    <= 1'b0;
    end else begin
      readback_valid_o <= do_cmd && cmd_read && chan_ok;
      write_done_o     <= do_write;
      cmd_ignored_o    <= (state_reg == QDSCD_DECODE) && !(tgt_ok && chan_ok);
      if (do_cmd && cmd_read && chan_ok) begin
        readback_data_o <= rd_value;
      end
    end
  end

  // ----------------------------------------------------------------
  // Code interpretation per channel
  // ----------------------------------------------------------------
  logic [NUM_CHAN-1:0][LEVEL_BITS-1:0] level_next;
  logic [NUM_CHAN-1:0]                 bipolar;

  // Signed level in steps: zero output is level zero
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      bipolar[i] = (range_reg[i][RANGE_BITS-1:0] >= RANGE_BIPOLAR_MIN);
      if (!bipolar[i]) begin
        level_next[i] = {1'b0, conv_reg[i][CODE_MSB:CODE_LSB]};
      end else if (coding_tc) begin
        level_next[i] = {conv_reg[i][CODE_MSB], conv_reg[i][CODE_MSB:CODE_LSB]};
      end else begin
        level_next[i] = {1'b0, conv_reg[i][CODE_MSB:CODE_LSB]} - OFFSET_MID;
      end
    end
  end

  // Register the channel outputs
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      chan_code_o    <= '0;
      chan_level_o   <= '0;
      chan_bipolar_o <= '0;
      chan_range_o   <= '0;
      power_ctrl_o   <= POWER_RST;
      gen_ctrl_o     <= CTRL_RST;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        chan_code_o[i]  <= conv_reg[i][CODE_MSB:CODE_LSB];
        chan_range_o[i] <= range_reg[i][RANGE_BITS-1:0];
      end
      chan_level_o   <= level_next;
      chan_bipolar_o <= bipolar;
      power_ctrl_o   <= power_reg;
      gen_ctrl_o     <= ctrl_reg;
    end
  end

endmodule : qdscd_decoder

`default_nettype wire

// ===== testbench/qdscd_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the decoder's ports for pulse and update ordering
module qdscd_checker (
  // Clocks and reset
  input wire logic                                                   mclk_i,
  input wire logic                                                   sys_rst_i,
  input wire logic                                                   serial_clock_i,
  // Link and pin inputs
  input wire logic                                                   frame_sync_n_i,
  input wire logic                                                   serial_data_input_i,
  input wire logic                                                   twos_comp_pin_i,
  // Channel outputs
  input wire logic [qdscd_pkg::NUM_CHAN-1:0][qdscd_pkg::CODE_BITS-1:0]  chan_code_o,
  input wire logic [qdscd_pkg::NUM_CHAN-1:0][qdscd_pkg::LEVEL_BITS-1:0] chan_level_o,
  input wire logic [qdscd_pkg::NUM_CHAN-1:0]                            chan_bipolar_o,
  input wire logic [qdscd_pkg::NUM_CHAN-1:0][qdscd_pkg::RANGE_BITS-1:0] chan_range_o,
  // Stores and status
  input wire logic [15:0]                                            power_ctrl_o,
  input wire logic [15:0]                                            gen_ctrl_o,
  input wire logic [15:0]                                            readback_data_o,
  input wire logic                                                   readback_valid_o,
  input wire logic                                                   write_done_o,
  input wire logic                                                   cmd_ignored_o
);
  import qdscd_pkg::*;

  logic [3:0] bip_exp;

  // Expected bipolar flags from the range fields
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bip_exp[i] = (chan_range_o[i] >= RANGE_BIPOLAR_MIN);
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  chk_pulse_one_hot: assert property ($onehot0({readback_valid_o, write_done_o, cmd_ignored_o}))
    else $error("two command pulses at once");
  chk_write_one_cycle: assert property (write_done_o |=> !write_done_o)
    else $error("write pulse too long");
  chk_read_one_cycle: assert property (readback_valid_o |=> !readback_valid_o)
    else $error("read pulse too long");
  chk_readback_hold: assert property ($changed(readback_data_o) |-> readback_valid_o)
    else $error("read data moved without a read");
  // Store outputs refresh one cycle after the write pulse
  chk_power_on_write: assert property ($changed(power_ctrl_o) |-> $past(write_done_o))
    else $error("power store moved without a write");
  chk_ctrl_on_write: assert property ($changed(gen_ctrl_o) |-> $past(write_done_o))
    else $error("control store moved without a write");
  chk_chan_on_write: assert property (($changed(chan_code_o) || $changed(chan_range_o)) |-> $past(write_done_o))
    else $error("channel store moved without a write");
  chk_ignored_no_change: assert property (cmd_ignored_o |=> $stable(chan_code_o) && $stable(chan_range_o)
    && $stable(power_ctrl_o) && $stable(gen_ctrl_o))
    else $error("ignored command changed a store");
  chk_bipolar_map: assert property (chan_bipolar_o == bip_exp)
    else $error("bipolar flag disagrees with range");
  chk_unipolar_level: assert property (!chan_bipolar_o[0] |-> chan_level_o[0] == {1'b0, chan_code_o[0]})
    else $error("unipolar level differs from code");

  // Main scenarios reached
  cover property (write_done_o);
  cover property (readback_valid_o);
  cover property (cmd_ignored_o);

endmodule : qdscd_checker

bind qdscd_decoder qdscd_checker chk_i (.mclk_i, .sys_rst_i, .serial_clock_i, .frame_sync_n_i,
  .serial_data_input_i, .twos_comp_pin_i, .chan_code_o, .chan_level_o, .chan_bipolar_o, .chan_range_o,
  .power_ctrl_o, .gen_ctrl_o, .readback_data_o, .readback_valid_o, .write_done_o, .cmd_ignored_o);

`default_nettype wire

// ===== testbench/qdscd_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host that frames command words onto the serial link
module qdscd_host (
  // Serial link to the decoder
  output var logic sclk_o,
  output var logic frame_n_o,
  output var logic sdata_o
);
  // Link idles with clock still and frame high
  initial begin
    sclk_o    = 1'b0;
    frame_n_o = 1'b1;
    sdata_o   = 1'b1;
  end

  // Shift n bits of w, bit 23 first
  task automatic send(input logic [23:0] w, input int n);
    logic [23:0] v;
    v     = w;
    v[22] = 1'b0;           // Reserved bit always zero
    #37;
    frame_n_o = 1'b0;
    for (int k = 0; k < n; k++) begin
      sdata_o = v[23-k];    // MSB first
      #16 sclk_o = 1'b1;
      #16 sclk_o = 1'b0;
    end
    frame_n_o = 1'b1;
    sdata_o   = ~sdata_o;   // Released line shows no stale bit
  endtask : send

endmodule : qdscd_host

`default_nettype wire

// ===== testbench/test_quad_dac_serial_command_decoder.sv
`timescale 1ns/1ps
`default_nettype none

// Drives command words and checks the decoded stores
module test_quad_dac_serial_command_decoder;
  import qdscd_pkg::*;

  logic                   mclk_i, sys_rst_i, twos_comp_pin_i;
  wire                    sclk, frm_n, sdi;
  logic [3:0][11:0]       chan_code_o;
  logic [3:0][12:0]       chan_level_o;
  logic [3:0]             chan_bipolar_o;
  logic [3:0][2:0]        chan_range_o;
  logic [15:0]            power_ctrl_o, gen_ctrl_o, readback_data_o;
  logic                   readback_valid_o, write_done_o, cmd_ignored_o;
  logic [2:0]             p;
  int                     err_total, cmp_count;
  logic [2:0]  rg_t [8] = '{3'h0, 3'h0, 3'h3, 3'h4, 3'h5, 3'h3, 3'h3, 3'h4};
  logic        pin_t [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [11:0] cd_t [8] = '{12'hFFF, 12'h001, 12'h800, 12'hFFF, 12'h000, 12'h7FF, 12'h800, 12'h000};
  logic [12:0] lv_t [8] = '{13'h0FFF, 13'h0001, 13'h0000, 13'h07FF, 13'h1800, 13'h07FF, 13'h1800, 13'h0000};

  qdscd_host host (.sclk_o(sclk), .frame_n_o(frm_n), .sdata_o(sdi));

  qdscd_decoder dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .serial_clock_i(sclk), .frame_sync_n_i(frm_n),
    .serial_data_input_i(sdi), .twos_comp_pin_i(twos_comp_pin_i), .chan_code_o(chan_code_o),
    .chan_level_o(chan_level_o), .chan_bipolar_o(chan_bipolar_o), .chan_range_o(chan_range_o),
    .power_ctrl_o(power_ctrl_o), .gen_ctrl_o(gen_ctrl_o), .readback_data_o(readback_data_o),
    .readback_valid_o(readback_valid_o), .write_done_o(write_done_o), .cmd_ignored_o(cmd_ignored_o));

  // System clock, 50 ns period
  always #25 mclk_i = ~mclk_i;

  // Compare one value
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // Wait a bounded time for a command pulse
  task automatic waitp(output logic [2:0] q);
    q = 3'h0;
    for (int k = 0; k < 40 && q == 3'h0; k++) begin
      @(negedge mclk_i);
      q = {readback_valid_o, write_done_o, cmd_ignored_o};
    end
  endtask : waitp

  // Send one full command and check its pulse
  task automatic cmd(input logic rw, input logic [2:0] t, input logic [2:0] c,
                     input logic [15:0] d, input logic [2:0] ep);
    host.send({rw, 1'b0, t, c, d}, 24);
    waitp(p);
    // Store outputs follow the pulse by one cycle
    @(negedge mclk_i);
    chk(p, ep);
  endtask : cmd

  // Print counts and verdict, then stop
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // Cut a hang short
  initial begin
    #300_000;
    err_total++;
    results();
  end

  // Main sequence
  initial begin
    mclk_i = 1'b0;
    sys_rst_i = 1'b1;
    twos_comp_pin_i = 1'b0;
    err_total = 0;
    cmp_count = 0;
    repeat (16) @(posedge mclk_i);
    #2 sys_rst_i = 1'b0;
    repeat (4) @(posedge mclk_i);
    chk({power_ctrl_o, gen_ctrl_o, readback_data_o}, 64'h0);
    chk({chan_code_o, chan_range_o}, 64'h0);
    $display("test 1 done");
    for (int i = 0; i < 4; i++) begin
      cmd(1'b0, TGT_CONV, 3'(i), {4'(i + 1), 12'hA50}, 3'h2);
      chk(chan_code_o[i], {4'(i + 1), 8'hA5});
      cmd(1'b1, TGT_CONV, 3'(i), 16'h0000, 3'h4);
      chk(readback_data_o, {4'(i + 1), 12'hA50});
    end
    $display("test 2 done");
    cmd(1'b0, TGT_CONV, CHAN_ALL, 16'h7E50, 3'h2);
    for (int i = 0; i < 4; i++) chk(chan_code_o[i], 12'h7E5);
    cmd(1'b1, TGT_CONV, CHAN_ALL, 16'h0000, 3'h4);
    chk(readback_data_o, 16'h7E50);
    $display("test 3 done");
    for (int j = 0; j < 8; j++) begin
      @(posedge mclk_i);
      #2 twos_comp_pin_i = pin_t[j];
      cmd(1'b0, TGT_RANGE, 3'h0, {13'h0, rg_t[j]}, 3'h2);
      chk(chan_range_o[0], rg_t[j]);
      cmd(1'b0, TGT_CONV, 3'h0, {cd_t[j], 4'hF}, 3'h2);
      chk(chan_code_o[0], cd_t[j]);
      chk(chan_level_o[0], lv_t[j]); // level
      chk(chan_bipolar_o[0], rg_t[j] >= 3'h3);
    end
    $display("test 4 done");
    cmd(1'b0, TGT_POWER, CHAN_ALL, 16'hA5A5, 3'h2);
    chk(power_ctrl_o, 16'hA5A5);
    cmd(1'b1, TGT_POWER, 3'h0, 16'h0000, 3'h4);
    chk(readback_data_o, 16'hA5A5);
    cmd(1'b0, TGT_CTRL, 3'h3, 16'h5A5A, 3'h2);
    chk(gen_ctrl_o, 16'h5A5A);
    cmd(1'b1, TGT_CTRL, 3'h0, 16'h0000, 3'h4);
    chk(readback_data_o, 16'h5A5A);
    cmd(1'b1, TGT_RANGE, 3'h0, 16'h0000, 3'h4);
    chk(readback_data_o, 16'h0004);
    $display("test 5 done");
    for (int t = 4; t < 8; t++) begin
      cmd(1'b0, 3'(t), 3'h0, 16'hFFFF, 3'h1);
      chk(chan_code_o[0], 12'h000);
    end
    for (int c = 5; c < 8; c++) begin
      cmd(1'b0, TGT_POWER, 3'(c), 16'h0000, 3'h1);
      chk(power_ctrl_o, 16'hA5A5);
    end
    $display("test 6 done");
    host.send({1'b0, 1'b0, TGT_CONV, 3'h0, 16'h1230}, 23);
    waitp(p);
    chk(p, 3'h0);
    chk(chan_code_o[0], 12'h000);
    cmd(1'b0, TGT_CONV, 3'h0, 16'h4560, 3'h2);
    chk(chan_code_o[0], 12'h456);
    $display("test 7 done");
    results();
  end

endmodule : test_quad_dac_serial_command_decoder

`default_nettype wire
